// ==== verilog/mic_pkg.sv ====
// Shared constants for the maskable interrupt controller
package mic_pkg;

  // Register addresses on the special function register port
  localparam logic [15:0] ADDR_REQ_FLAGS = 16'hffe0;
  localparam logic [15:0] ADDR_MASK_FLAGS = 16'hffe4;

  // Reset values
  localparam logic [7:0] REQ_FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_FLAGS_RESET = 8'hff;
  localparam logic [7:0] STATUS_WORD_RESET = 8'h02;

  // Bit 0 of the request register is fixed low, of the mask register fixed high
  localparam logic [7:0] REQ_FLAGS_USED = 8'hfe;
  localparam logic [7:0] MASK_FIXED_ONES = 8'h01;

  // Position of the global enable bit inside the status word
  localparam int STATUS_IE_BIT = 7;

  // Number of maskable sources; bit i of the flag registers is source i
  localparam int NUM_SRC = 7;

  // Flag bit positions, priority order 1 (highest) to 7 (lowest)
  localparam int BIT_LOW_VOLTAGE = 1;
  localparam int BIT_PIN0 = 2;
  localparam int BIT_PIN1 = 3;
  localparam int BIT_TIMER_H = 4;
  localparam int BIT_TIMER0_CH0 = 5;
  localparam int BIT_TIMER0_CH1 = 6;
  localparam int BIT_CONVERTER = 7;

  // Vector table, indexed by flag bit position (entry 0 is the restart vector)
  localparam logic [15:0] RESTART_VEC = 16'h0000;
  localparam logic [15:0] VEC_TABLE [0:7] = '{
    RESTART_VEC, 16'h0006, 16'h0008, 16'h000a,
    16'h000c, 16'h000e, 16'h0010, 16'h0012
  };

  // Edge selection codes for the external pins
  typedef enum logic [1:0] {
    MIC_EDGE_FALL,
    MIC_EDGE_RISE,
    MIC_EDGE_NONE,
    MIC_EDGE_BOTH
  } mic_edge_t;

endpackage

// ==== verilog/mic_pin_edge.sv ====
`timescale 1ns/10ps
// Synchronised edge detector for one external request pin
module mic_pin_edge #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Pin and port-output view
  input wire logic PIN_IN,
  input wire logic PORT_OUT_LEVEL,
  input wire logic PORT_OUT_MODE,
  input wire mic_pkg::mic_edge_t EDGE_MODE,
  // One-cycle request pulse
  output logic EDGE_EVENT
);
  import mic_pkg::*;

  // At least two flops are needed to tame metastability
  if (SYNC_STAGES < 2) begin : g_bad_stages
    $error("mic_pin_edge needs SYNC_STAGES of at least 2");
  end

  logic [SYNC_STAGES-1:0] sync_r; // Pin synchroniser chain
  logic level; // Level seen by the detector
  logic prev_r; // Level one cycle ago
  // Blocks edges until the chain and the previous level have filled;
  // one cycle is too short, since a pin idling high reaches the detector late
  logic [SYNC_STAGES:0] prime_r;
  logic rise;
  logic fall;
  logic hit;

  // Synchroniser; only the chain itself reads the early stages
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[SYNC_STAGES-2:0], PIN_IN};
    end
  end

  // In output mode the pin follows the port latch, so its changes count
  assign level = PORT_OUT_MODE ? PORT_OUT_LEVEL : sync_r[SYNC_STAGES-1];
  assign rise = level && !prev_r;
  assign fall = !level && prev_r;
  assign hit = prime_r[SYNC_STAGES] && (((EDGE_MODE == MIC_EDGE_RISE) && rise) ||
               ((EDGE_MODE == MIC_EDGE_FALL) && fall) ||
               ((EDGE_MODE == MIC_EDGE_BOTH) && (rise || fall)));

  // Previous level and the single event pulse per edge
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      prev_r <= 1'b0;
      prime_r <= '0;
      EDGE_EVENT <= 1'b0;
    end else begin
      prev_r <= level;
      prime_r <= {prime_r[SYNC_STAGES-1:0], 1'b1};
      EDGE_EVENT <= hit;
    end
  end

endmodule

// ==== verilog/mic_ctrl.sv ====
`timescale 1ns/10ps
module mic_ctrl #(
  parameter int ADDR_W = 16,
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Special function register port
  input wire logic [ADDR_W-1:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic SFR_BIT_OP,
  input wire logic [2:0] SFR_BIT_SEL,
  input wire logic SFR_BIT_VAL,
  output logic [7:0] SFR_RDATA,
  // Status word access from the core
  input wire logic PSW_WR,
  input wire logic [7:0] PSW_WDATA,
  input wire logic PSW_BIT_OP,
  input wire logic [2:0] PSW_BIT_SEL,
  input wire logic PSW_BIT_VAL,
  input wire logic UNMASK_ALL_OP,
  input wire logic MASK_ALL_OP,
  output logic [7:0] PSW_OUT,
  // Internal request sources, one-cycle pulses
  input wire logic LOW_VOLTAGE_DET,
  input wire logic LOW_VOLTAGE_RESET_SEL,
  input wire logic TIMER_H_MATCH,
  input wire logic TIMER0_CH0_EVT,
  input wire logic TIMER0_CH1_EVT,
  input wire logic CONVERTER_DONE,
  // External request pins and their port-output view
  input wire logic PIN0_IN,
  input wire logic PIN0_PORT_OUT,
  input wire logic PIN0_OUT_MODE,
  input wire mic_pkg::mic_edge_t PIN0_EDGE_MODE,
  input wire logic PIN1_IN,
  input wire logic PIN1_PORT_OUT,
  input wire logic PIN1_OUT_MODE,
  input wire mic_pkg::mic_edge_t PIN1_EDGE_MODE,
  // Vectoring handshake with the core
  output logic INT_REQ,
  output logic [15:0] INT_VECTOR,
  input wire logic INT_ACK,
  output logic PSW_PUSH,
  output logic [7:0] STACK_PSW,
  // Reset sources and restart request
  input wire logic RESET_PIN_N,
  input wire logic POWER_ON_CLEAR,
  input wire logic WATCHDOG_OVERFLOW,
  output logic RESET_REQ,
  output logic [15:0] RESTART_VECTOR
);
  import mic_pkg::*;

  // The decoder compares against 16-bit addresses
  if (ADDR_W < 16) begin : g_bad_addr
    $error("mic_ctrl needs ADDR_W of at least 16");
  end

  // Stored state
  logic [7:0] req_r; // Request flags, one bit per source
  logic [7:0] mask_r; // Mask flags, one bit per source
  logic [7:0] psw_r; // Status word with the global enable
  logic [2:0] sel_r; // Source being offered to the core
  logic rpin_s1_r; // Reset pin synchroniser, first flop
  logic rpin_s2_r; // Reset pin synchroniser, second flop

  // Next values
  logic [7:0] req_nxt;
  logic [7:0] mask_nxt;
  logic [7:0] psw_nxt;
  logic [2:0] sel_nxt;

  // Decoded accesses
  wire hit_req = (SFR_ADDR == ADDR_W'(ADDR_REQ_FLAGS));
  wire hit_mask = (SFR_ADDR == ADDR_W'(ADDR_MASK_FLAGS));
  wire req_wr = SFR_WR && hit_req;
  wire mask_wr = SFR_WR && hit_mask;
  wire flag_access = (SFR_WR || SFR_RD) && (hit_req || hit_mask);

  // Bit-access helpers shared by both flag registers
  wire [7:0] sfr_bit = 8'h01 << SFR_BIT_SEL;
  wire [7:0] sfr_bit_set = SFR_BIT_VAL ? sfr_bit : 8'h00;
  wire [7:0] req_wval = SFR_BIT_OP ? ((req_r & ~sfr_bit) | sfr_bit_set) : SFR_WDATA;
  wire [7:0] mask_wval = SFR_BIT_OP ? ((mask_r & ~sfr_bit) | sfr_bit_set) : SFR_WDATA;

  // Pin edge events
  logic pin0_evt;
  logic pin1_evt;

  // Low-voltage detection goes to either the flag or the reset path
  wire lv_irq = LOW_VOLTAGE_DET && !LOW_VOLTAGE_RESET_SEL;
  wire lv_rst = LOW_VOLTAGE_DET && LOW_VOLTAGE_RESET_SEL;

  // Hardware set vector, each source on its own bit
  logic [7:0] src_set;
  always_comb begin
    src_set = 8'h00;
    src_set[BIT_LOW_VOLTAGE] = lv_irq;
    src_set[BIT_PIN0] = pin0_evt;
    src_set[BIT_PIN1] = pin1_evt;
    src_set[BIT_TIMER_H] = TIMER_H_MATCH;
    src_set[BIT_TIMER0_CH0] = TIMER0_CH0_EVT;
    src_set[BIT_TIMER0_CH1] = TIMER0_CH1_EVT;
    src_set[BIT_CONVERTER] = CONVERTER_DONE;
  end

  // Global enable and eligibility
  wire ie = psw_r[STATUS_IE_BIT];
  wire [7:0] eligible = req_r & ~mask_r & REQ_FLAGS_USED & {8{ie}};
  wire ack_ok = INT_ACK && INT_REQ;
  wire [7:0] ack_clr = ack_ok ? (8'h01 << sel_r) : 8'h00;

  // Lowest set bit wins; scanning downward leaves the highest priority last
  always_comb begin
    sel_nxt = 3'h0;
    for (int i = NUM_SRC; i >= 1; i--) begin
      if (eligible[i]) begin
        sel_nxt = 3'(i);
      end
    end
  end

  // Request flags: software write, then acknowledge clear, then source set
  // Sources are ORed in last so an event in the clearing cycle is kept
  assign req_nxt = (((req_wr ? req_wval : req_r) & ~ack_clr) | src_set)
                   & REQ_FLAGS_USED;

  // Mask flags: bit 0 has no source and reads as one
  assign mask_nxt = mask_wr ? (mask_wval | MASK_FIXED_ONES) : mask_r;

  // Status word: byte or bit write, dedicated ops, acknowledge last
  logic [7:0] psw_bit;
  logic [7:0] psw_wval;
  always_comb begin
    psw_bit = 8'h01 << PSW_BIT_SEL;
    psw_wval = psw_r;
    if (PSW_WR) begin
      psw_wval = PSW_BIT_OP ? ((psw_r & ~psw_bit) | (PSW_BIT_VAL ? psw_bit : 8'h00))
                            : PSW_WDATA;
    end
    psw_nxt = psw_wval;
    if (UNMASK_ALL_OP) begin
      psw_nxt[STATUS_IE_BIT] = 1'b1;
    end
    if (MASK_ALL_OP) begin
      psw_nxt[STATUS_IE_BIT] = 1'b0;
    end
    if (ack_ok) begin
      psw_nxt[STATUS_IE_BIT] = 1'b0;
    end
  end

  // Flag and status registers
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_r <= REQ_FLAGS_RESET;
      mask_r <= MASK_FLAGS_RESET;
      psw_r <= STATUS_WORD_RESET;
    end else begin
      req_r <= req_nxt;
      mask_r <= mask_nxt;
      psw_r <= psw_nxt;
    end
  end

  // Offer to the core; a flag register access holds it off one cycle
  // Acknowledge drops the offer directly, since eligible still sees the old enable in that cycle
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      INT_REQ <= 1'b0;
      sel_r <= 3'h0;
      INT_VECTOR <= RESTART_VEC;
    end else begin
      INT_REQ <= (|eligible) && !flag_access && !ack_ok;
      sel_r <= sel_nxt;
      INT_VECTOR <= VEC_TABLE[sel_nxt];
    end
  end

  // Status word handed to the stack on acknowledge
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      PSW_PUSH <= 1'b0;
      STACK_PSW <= STATUS_WORD_RESET;
    end else begin
      PSW_PUSH <= ack_ok;
      if (ack_ok) begin
        STACK_PSW <= psw_r;
      end
    end
  end

  // Register read data, one cycle after the read strobe
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
      if (hit_req) begin
        SFR_RDATA <= req_r;
      end else if (hit_mask) begin
        SFR_RDATA <= mask_r;
      end else begin
        SFR_RDATA <= 8'h00;
      end
    end
  end

  assign PSW_OUT = psw_r;

  // Reset pin synchroniser
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rpin_s1_r <= 1'b1;
      rpin_s2_r <= 1'b1;
    end else begin
      rpin_s1_r <= RESET_PIN_N;
      rpin_s2_r <= rpin_s1_r;
    end
  end

  // Unmaskable restart request; nothing here can gate it
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_REQ <= 1'b0;
    end else begin
      RESET_REQ <= !rpin_s2_r || POWER_ON_CLEAR || WATCHDOG_OVERFLOW || lv_rst;
    end
  end

  assign RESTART_VECTOR = VEC_TABLE[0];

  // Edge-mode changes are only safe with the source masked (software duty)
  mic_pin_edge #(
    .SYNC_STAGES(SYNC_STAGES)
  ) u_pin0 (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .PIN_IN(PIN0_IN),
    .PORT_OUT_LEVEL(PIN0_PORT_OUT),
    .PORT_OUT_MODE(PIN0_OUT_MODE),
    .EDGE_MODE(PIN0_EDGE_MODE),
    .EDGE_EVENT(pin0_evt)
  );

  // Second external pin
  mic_pin_edge #(
    .SYNC_STAGES(SYNC_STAGES)
  ) u_pin1 (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .PIN_IN(PIN1_IN),
    .PORT_OUT_LEVEL(PIN1_PORT_OUT),
    .PORT_OUT_MODE(PIN1_OUT_MODE),
    .EDGE_MODE(PIN1_EDGE_MODE),
    .EDGE_EVENT(pin1_evt)
  );

  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  // Acknowledge of a live offer, then its effects one cycle on
  sequence s_ack;
    INT_ACK && INT_REQ;
  endsequence

  sequence s_ack_done;
    !psw_r[STATUS_IE_BIT] && PSW_PUSH && !INT_REQ;
  endsequence

  // No offer without a flag, clear mask and enable one cycle before
  gate_offer_a: assert property (
    INT_REQ |-> $past(ie && |(req_r & ~mask_r & REQ_FLAGS_USED)))
    else $error("offer without an eligible source");

  // Nothing of higher priority was eligible when the offer was chosen
  prio_win_a: assert property (
    INT_REQ |-> (($past(eligible) & ((8'h01 << sel_r) - 8'h01)) == 8'h00)
                && (($past(eligible) & (8'h01 << sel_r)) != 8'h00))
    else $error("offered source is not the highest priority");

  // Offered vector matches the chosen source
  vec_map_a: assert property (
    INT_REQ |-> INT_VECTOR == 16'h0004 + {12'h000, sel_r, 1'b0})
    else $error("vector does not match the chosen source");

  // Acknowledge drops enable, pushes status word, withdraws offer
  ack_effect_a: assert property (
    s_ack |=> s_ack_done)
    else $error("acknowledge did not clear enable and push");

  // Acknowledge clears the served flag unless its source fires again
  ack_clear_a: assert property (
    s_ack ##0 !src_set[sel_r] ##0 !(req_wr && req_wval[sel_r]) |=> !req_r[$past(sel_r)])
    else $error("acknowledged flag still set");

  // A timer H event is never lost, even while cleared
  src_set_a: assert property (
    TIMER_H_MATCH |=> req_r[BIT_TIMER_H])
    else $error("timer event lost");

  // Access to the flag registers withholds the offer
  hold_access_a: assert property (
    flag_access |=> !INT_REQ)
    else $error("offer during flag register access");

  // Low-voltage in reset mode restarts and leaves its flag alone
  lv_route_a: assert property (
    lv_rst && !req_r[BIT_LOW_VOLTAGE] && !(req_wr && req_wval[BIT_LOW_VOLTAGE])
      |=> RESET_REQ && !req_r[BIT_LOW_VOLTAGE])
    else $error("low-voltage reset mode misrouted");

  // Watchdog overflow always restarts
  wdt_reset_a: assert property (
    WATCHDOG_OVERFLOW |=> RESET_REQ)
    else $error("watchdog overflow did not restart");

  // Bit 0 of request and mask registers stays fixed
  fixed_bits_a: assert property (
    !req_r[0] && mask_r[0])
    else $error("fixed flag bit changed");

  // Dedicated disable op without acknowledge lowers the enable
  mask_all_a: assert property (
    MASK_ALL_OP |=> !psw_r[STATUS_IE_BIT])
    else $error("disable op did not clear enable");

endmodule

// ==== test/mic_core_model.sv ====
`timescale 1ns/10ps
// Core model: takes an offered vector after a programmable wait
module mic_core_model (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Offer from the controller
  input wire logic INT_REQ,
  input wire logic [15:0] INT_VECTOR,
  input wire logic [3:0] ACK_DELAY,
  // Acceptance and the vector taken
  output logic INT_ACK,
  output logic [15:0] TAKEN_VEC
);
  logic [3:0] wait_r; // Cycles the offer has stood
  // A withdrawn offer restarts the wait, as a real core would re-sample
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wait_r <= 4'h0;
      INT_ACK <= 1'b0;
      TAKEN_VEC <= 16'h0000;
    end else if (INT_ACK) begin
      INT_ACK <= 1'b0;
      wait_r <= 4'h0;
      if (INT_REQ) TAKEN_VEC <= INT_VECTOR;
    end else if (INT_REQ && wait_r >= ACK_DELAY) begin
      INT_ACK <= 1'b1;
    end else if (INT_REQ) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule

// ==== test/mic_tb_top.sv ====
`timescale 1ns/10ps
// Self-checking bench for the interrupt controller
module maskable_interrupt_controller_tb_top;
  import mic_pkg::*;
  // Clock, reset and counters
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  int err_total = 0;
  int n_compared = 0;
  // Register port and status word controls
  logic [15:0] sfr_addr = 16'h0000;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bop = 1'b0, sfr_bval = 1'b0;
  logic [2:0] sfr_bsel = 3'h0;
  logic psw_wr = 1'b0, psw_bop = 1'b0, unmask_op = 1'b0, mask_op = 1'b0;
  logic [7:0] psw_wdata = 8'h00;
  // Sources: lvd, timer h, timer0 ch0/ch1, converter, watchdog, power-on
  logic lvd = 1'b0, tmh = 1'b0, t0c0 = 1'b0, t0c1 = 1'b0, adc = 1'b0;
  logic wdt = 1'b0, power_on_clear = 1'b0, lvd_sel = 1'b0, rst_pin_n = 1'b1;
  // Pins idle high for pin0, low for pin1
  logic pin0 = 1'b1, pin1 = 1'b0, pin1_po = 1'b0, pin1_om = 1'b0;
  mic_edge_t pin0_em = MIC_EDGE_FALL;
  mic_edge_t pin1_em = MIC_EDGE_RISE;
  logic [3:0] ack_delay = 4'hf;
  // Outputs
  logic [7:0] sfr_rdata, psw_out, stack_psw;
  logic int_req, int_ack, psw_push, reset_req;
  logic [15:0] int_vector, restart_vector, taken_vec;

  always #5 clock = ~clock;

  mic_ctrl mic_ctrl_inst (.CLOCK(clock), .RESET_N(reset_n), .SFR_ADDR(sfr_addr),
    .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_BIT_OP(sfr_bop),
    .SFR_BIT_SEL(sfr_bsel), .SFR_BIT_VAL(sfr_bval), .SFR_RDATA(sfr_rdata),
    .PSW_WR(psw_wr), .PSW_WDATA(psw_wdata), .PSW_BIT_OP(psw_bop), .PSW_BIT_SEL(3'h7),
    .PSW_BIT_VAL(psw_wdata[7]), .UNMASK_ALL_OP(unmask_op), .MASK_ALL_OP(mask_op),
    .PSW_OUT(psw_out), .LOW_VOLTAGE_DET(lvd), .LOW_VOLTAGE_RESET_SEL(lvd_sel),
    .TIMER_H_MATCH(tmh), .TIMER0_CH0_EVT(t0c0), .TIMER0_CH1_EVT(t0c1),
    .CONVERTER_DONE(adc), .PIN0_IN(pin0), .PIN0_PORT_OUT(1'b1), .PIN0_OUT_MODE(1'b0),
    .PIN0_EDGE_MODE(pin0_em), .PIN1_IN(pin1), .PIN1_PORT_OUT(pin1_po),
    .PIN1_OUT_MODE(pin1_om), .PIN1_EDGE_MODE(pin1_em), .INT_REQ(int_req),
    .INT_VECTOR(int_vector), .INT_ACK(int_ack), .PSW_PUSH(psw_push),
    .STACK_PSW(stack_psw), .RESET_PIN_N(rst_pin_n), .POWER_ON_CLEAR(power_on_clear),
    .WATCHDOG_OVERFLOW(wdt), .RESET_REQ(reset_req), .RESTART_VECTOR(restart_vector));

  mic_core_model mic_core_model_inst (.CLOCK(clock), .RESET_N(reset_n),
    .INT_REQ(int_req), .INT_VECTOR(int_vector), .ACK_DELAY(ack_delay),
    .INT_ACK(int_ack), .TAKEN_VEC(taken_vec));

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write on the register port, byte or single bit
  task automatic sfr_write(input logic [15:0] a, input logic [7:0] d, input logic bop);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_bop <= bop;
    sfr_bsel <= d[2:0];
    sfr_bval <= d[7];
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask

  // Read; data is registered, so look just after the taking edge
  task automatic sfr_check(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1;
    check(16'(sfr_rdata), 16'(exp));
  endtask

  // Status word access: byte write, bit write, enable op, disable op
  task automatic psw_op(input logic [3:0] k, input logic [7:0] d);
    @(posedge clock);
    psw_wdata <= d;
    {mask_op, unmask_op, psw_bop, psw_wr} <= {k[3], k[2], k[1], k[1] | k[0]};
    @(posedge clock);
    {mask_op, unmask_op, psw_bop, psw_wr} <= 4'h0;
    #1;
  endtask

  // One-cycle pulse on the sources
  task automatic pulse(input logic [6:0] m);
    @(posedge clock);
    {power_on_clear, wdt, adc, t0c1, t0c0, tmh, lvd} <= m;
    @(posedge clock);
    {power_on_clear, wdt, adc, t0c1, t0c0, tmh, lvd} <= 7'h00;
    #1;
  endtask

  // Bounded wait for the stacking pulse
  task automatic wait_push();
    int n;
    n = 0;
    while (psw_push !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(16'(n < 40), 16'h0001);
  endtask

  task automatic test_regs();
    check(16'(psw_out), 16'h0002);
    sfr_check(ADDR_REQ_FLAGS, 8'h00);
    sfr_check(ADDR_MASK_FLAGS, 8'hff);
    sfr_write(ADDR_REQ_FLAGS, 8'hff, 1'b0);
    sfr_check(ADDR_REQ_FLAGS, 8'hfe);
    sfr_write(ADDR_REQ_FLAGS, 8'h07, 1'b1);
    sfr_check(ADDR_REQ_FLAGS, 8'h7e);
    sfr_write(ADDR_REQ_FLAGS, 8'h00, 1'b0);
    sfr_write(ADDR_MASK_FLAGS, 8'h01, 1'b1);
    sfr_check(ADDR_MASK_FLAGS, 8'hfd);
    sfr_write(ADDR_MASK_FLAGS, 8'hff, 1'b0);
    psw_op(4'h2, 8'h80);
    check(16'(psw_out), 16'h0082);
    psw_op(4'h8, 8'h00);
    check(16'(psw_out), 16'h0002);
    psw_op(4'h1, 8'h82);
    check(16'(psw_out), 16'h0082);
    psw_op(4'h8, 8'h00);
    $display("test registers done");
  endtask

  task automatic test_pins();
    pin0 <= 1'b0;
    repeat (8) @(posedge clock);
    sfr_check(ADDR_REQ_FLAGS, 8'h04);
    pin1_om <= 1'b1;
    repeat (4) @(posedge clock);
    pin1_po <= 1'b1;
    repeat (4) @(posedge clock);
    sfr_check(ADDR_REQ_FLAGS, 8'h0c);
    sfr_write(ADDR_REQ_FLAGS, 8'h00, 1'b0);
    repeat (8) @(posedge clock);
    sfr_check(ADDR_REQ_FLAGS, 8'h00);
    // Sources stay masked while the edge mode changes, flag cleared after
    pin0_em <= MIC_EDGE_NONE;
    pin0 <= 1'b1;
    repeat (8) @(posedge clock);
    sfr_check(ADDR_REQ_FLAGS, 8'h00);
    pin0_em <= MIC_EDGE_BOTH;
    pin0 <= 1'b0;
    repeat (8) @(posedge clock);
    sfr_check(ADDR_REQ_FLAGS, 8'h04);
    sfr_write(ADDR_REQ_FLAGS, 8'h00, 1'b0);
    pin0 <= 1'b1;
    repeat (8) @(posedge clock);
    sfr_check(ADDR_REQ_FLAGS, 8'h04);
    sfr_write(ADDR_REQ_FLAGS, 8'h00, 1'b0);
    sfr_check(ADDR_REQ_FLAGS, 8'h00);
    $display("test pins done");
  endtask

  task automatic test_vectors();
    logic [15:0] vec [0:4];
    vec = '{16'h0006, 16'h000c, 16'h000e, 16'h0010, 16'h0012};
    psw_op(4'h4, 8'h00);
    pulse(7'h02);
    repeat (4) @(posedge clock);
    check(16'(int_req), 16'h0000);
    sfr_check(ADDR_REQ_FLAGS, 8'h10);
    psw_op(4'h8, 8'h00);
    sfr_write(ADDR_MASK_FLAGS, 8'h00, 1'b0);
    repeat (4) @(posedge clock);
    check(16'(int_req), 16'h0000);
    pulse(7'h1f);
    psw_op(4'h4, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    check(16'(int_req), 16'h0001);
    sfr_check(ADDR_REQ_FLAGS, 8'hf2);
    check(16'(int_req), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      ack_delay <= i[0] ? 4'h3 : 4'h0;
      if (i > 0) psw_op(4'h4, 8'h00);
      wait_push();
      check(taken_vec, vec[i]);
      check(16'(psw_out[7]), 16'h0000);
      check(16'(stack_psw), 16'h0082);
    end
    sfr_check(ADDR_REQ_FLAGS, 8'h00);
    $display("test vectors done");
  endtask

  task automatic test_resets();
    pulse(7'h20);
    check(16'(reset_req), 16'h0001);
    check(restart_vector, 16'h0000);
    pulse(7'h40);
    check(16'(reset_req), 16'h0001);
    lvd_sel <= 1'b1;
    pulse(7'h01);
    check(16'(reset_req), 16'h0001);
    sfr_check(ADDR_REQ_FLAGS, 8'h00);
    rst_pin_n <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    check(16'(reset_req), 16'h0001);
    rst_pin_n <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check(16'(reset_req), 16'h0000);
    $display("test resets done");
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d failed", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    test_regs();
    test_pins();
    test_vectors();
    test_resets();
    give_verdict();
  end
endmodule
